/* verilog/mxb_pkg.sv */
// package for the multiplexed expansion bus sequencer
package mxb_pkg;
  localparam int unsigned AW = 16;
  localparam int unsigned DW = 16;
  localparam int unsigned SHORT_W = 2;
  localparam int unsigned LONG_W = 4;
  localparam logic [SHORT_W-1:0] ADDR_LEN_RST = 2'h0;
  localparam logic [SHORT_W-1:0] SETUP_LEN_RST = 2'h0;
  localparam logic [LONG_W-1:0] STROBE_LEN_RST = 4'h0;
  localparam logic [SHORT_W-1:0] HOLD_LEN_RST = 2'h0;
  localparam logic [LONG_W-1:0] RECOV_LEN_RST = 4'h0;
  localparam logic [LONG_W-1:0] CNT_RST = 4'h0;
  localparam logic [LONG_W-1:0] ONE = 4'h1;

  typedef enum logic [2:0] {
    MXB_IDLE = 3'b000,
    MXB_ADDR = 3'b001,
    MXB_SETUP = 3'b010,
    MXB_STROBE = 3'b011,
    MXB_HOLD = 3'b100,
    MXB_RECOV = 3'b101
  } mxb_state_t;

  typedef struct packed {
    logic [SHORT_W-1:0] address_phase_len;
    logic [SHORT_W-1:0] setup_phase_len;
    logic [LONG_W-1:0] strobe_phase_len;
    logic [SHORT_W-1:0] hold_phase_len;
    logic [LONG_W-1:0] recovery_phase_len;
  } mxb_timing_t;

  typedef struct packed {
    logic write;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } mxb_req_t;
endpackage

/* verilog/mxb_phase_cnt.sv */
// phase length down-counter for the sequencer
`timescale 1ns/1ps
`default_nettype none
module mxb_phase_cnt #(
  parameter int unsigned W = 4
) (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // sync reset
  input wire logic clk_en, // freeze when low
  input wire logic load, // start a phase
  input wire logic [W-1:0] len_m1, // phase length minus one
  output logic last // final cycle of the phase
);
  logic [W-1:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = len_m1;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  assign last = (cnt_q == '0);
endmodule
`default_nettype wire

/* verilog/mxb_seq.sv */
// strobe and phase sequencer for multiplexed expansion bus accesses
// Functional notes
// - data held 1 to 4 cycles after strobe
// - chip select 1-4 cycles after latch falls
// - recovery gap of 1 to 16 cycles
// - address phase length sets address time
// - setup length sets data before strobe
// - strobe length sets strobe width, data valid
// - hold length keeps select and write data
// - every count is one bus clock
// - latch pulse 1-4 cycles, address valid
// - write data valid 1-4 cycles before strobe
// - strobe low for 1 to 16 cycles
`timescale 1ns/1ps
`default_nettype none
module mxb_seq (
  input wire logic sys_clk, // expansion bus clock
  input wire logic reset_n, // sync reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire mxb_pkg::mxb_timing_t timing, // phase lengths minus one
  input wire mxb_pkg::mxb_req_t req, // access request
  input wire logic req_valid, // request offered
  input wire logic [mxb_pkg::DW-1:0] ad_in, // pad input of shared lines
  output logic req_ready, // request taken in the previous cycle
  output logic address_latch_strobe, // address latch, high pulse
  output logic cs_low, // chip select, active low
  output logic data_strobe_low, // data strobe, active low
  output logic rnw, // high on reads
  output logic [mxb_pkg::DW-1:0] ad_out, // shared address/data drive
  output logic ad_oe, // high while driving shared lines
  output logic [mxb_pkg::DW-1:0] rdata, // captured read data
  output logic rdata_valid, // one-cycle pulse with rdata
  output logic busy // access or recovery in progress
);
  mxb_pkg::mxb_state_t st_q, st_d;
  mxb_pkg::mxb_req_t cur_q, cur_d;
  logic [mxb_pkg::DW-1:0] ad_s1_q, ad_s2_q;
  logic [mxb_pkg::DW-1:0] rdata_q, rdata_d;
  logic rdv_q, rdv_d, rdy_q, rdy_d;
  logic ale_q, ale_d, cs_q, cs_d, ds_q, ds_d, oe_q, oe_d, busy_q, busy_d;
  logic dat_d;
  logic [mxb_pkg::DW-1:0] ado_q, ado_d;
  logic load, last;
  logic [mxb_pkg::LONG_W-1:0] len_m1;

  function automatic logic [mxb_pkg::LONG_W-1:0] widen(
    input logic [mxb_pkg::SHORT_W-1:0] v);
    widen = {{(mxb_pkg::LONG_W-mxb_pkg::SHORT_W){1'b0}}, v};
  endfunction

  // one count per bus clock
  mxb_phase_cnt #(.W(mxb_pkg::LONG_W)) u_cnt (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(load),
    .len_m1(len_m1),
    .last(last)
  );

  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    rdata_d = rdata_q;
    rdv_d = 1'b0;
    rdy_d = 1'b0;
    load = 1'b0;
    len_m1 = mxb_pkg::CNT_RST;
    case (st_q)
      mxb_pkg::MXB_IDLE: begin
        if (req_valid && !rdy_q) begin
          cur_d = req;
          rdy_d = 1'b1;
          st_d = mxb_pkg::MXB_ADDR;
          load = 1'b1;
          len_m1 = widen(timing.address_phase_len);
        end
      end
      mxb_pkg::MXB_ADDR: begin
        if (last) begin
          st_d = mxb_pkg::MXB_SETUP;
          load = 1'b1;
          len_m1 = widen(timing.setup_phase_len);
        end
      end
      mxb_pkg::MXB_SETUP: begin
        if (last) begin
          st_d = mxb_pkg::MXB_STROBE;
          load = 1'b1;
          len_m1 = timing.strobe_phase_len;
        end
      end
      mxb_pkg::MXB_STROBE: begin
        if (last) begin
          st_d = mxb_pkg::MXB_HOLD;
          load = 1'b1;
          len_m1 = widen(timing.hold_phase_len);
          if (!cur_q.write) begin
            rdata_d = ad_s2_q;
            rdv_d = 1'b1;
          end
        end
      end
      mxb_pkg::MXB_HOLD: begin
        if (last) begin
          st_d = mxb_pkg::MXB_RECOV;
          load = 1'b1;
          len_m1 = timing.recovery_phase_len;
        end
      end
      mxb_pkg::MXB_RECOV: begin
        if (last) begin
          st_d = mxb_pkg::MXB_IDLE;
        end
      end
      default: begin
        st_d = mxb_pkg::MXB_IDLE;
      end
    endcase
  end

  // registered pin levels follow the next state
  always_comb begin
    ale_d = (st_d == mxb_pkg::MXB_ADDR);
    // data phases: setup, strobe and hold
    dat_d = (st_d == mxb_pkg::MXB_SETUP) || (st_d == mxb_pkg::MXB_STROBE)
      || (st_d == mxb_pkg::MXB_HOLD);
    // select follows the setup phase, so it lags the latch by 1 to 4 cycles
    cs_d = (st_d == mxb_pkg::MXB_STROBE) || (st_d == mxb_pkg::MXB_HOLD);
    ds_d = (st_d == mxb_pkg::MXB_STROBE);
    busy_d = (st_d != mxb_pkg::MXB_IDLE);
    oe_d = (st_d == mxb_pkg::MXB_ADDR) || (cur_d.write && dat_d);
    ado_d = (st_d == mxb_pkg::MXB_ADDR) ? cur_d.addr : cur_d.wdata;
    if (!dat_d && st_d != mxb_pkg::MXB_ADDR) begin
      ado_d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q <= mxb_pkg::MXB_IDLE;
      cur_q <= '0;
      ad_s1_q <= '0;
      ad_s2_q <= '0;
      rdata_q <= '0;
      rdv_q <= 1'b0;
      rdy_q <= 1'b0;
      ale_q <= 1'b0;
      cs_q <= 1'b0;
      ds_q <= 1'b0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      ado_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      cur_q <= cur_d;
      ad_s1_q <= ad_in;
      ad_s2_q <= ad_s1_q;
      rdata_q <= rdata_d;
      rdv_q <= rdv_d;
      rdy_q <= rdy_d;
      ale_q <= ale_d;
      cs_q <= cs_d;
      ds_q <= ds_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
      ado_q <= ado_d;
    end
  end

  assign req_ready = rdy_q;
  assign address_latch_strobe = ale_q;
  assign cs_low = !cs_q;
  assign data_strobe_low = !ds_q;
  assign rnw = !cur_q.write;
  assign ad_out = ado_q;
  assign ad_oe = oe_q;
  assign rdata = rdata_q;
  assign rdata_valid = rdv_q;
  assign busy = busy_q;
endmodule
`default_nettype wire

/* tb/mxb_seq_asserts.sv */
// timing assertions for the expansion bus sequencer
`timescale 1ns/1ps
`default_nettype none
module mxb_seq_asserts (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // reset
  input wire mxb_pkg::mxb_timing_t timing, // lengths
  input wire logic req_ready, // taken
  input wire logic address_latch_strobe, // latch
  input wire logic cs_low, // select
  input wire logic data_strobe_low, // strobe
  input wire logic rnw, // read
  input wire logic [mxb_pkg::DW-1:0] ad_out, // lines
  input wire logic ad_oe, // enable
  input wire logic busy // active
);
  logic [7:0] t_q, ea, es, ed, eh;
  assign ea = 8'(timing.address_phase_len) + 8'h1;
  assign es = ea + 8'(timing.setup_phase_len) + 8'h1;
  assign ed = es + 8'(timing.strobe_phase_len) + 8'h1;
  assign eh = ed + 8'(timing.hold_phase_len) + 8'h1;
  // cycles since the latch rose
  always_ff @(posedge sys_clk) t_q <= $rose(address_latch_strobe) ? 8'h1 : t_q + 8'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take; req_ready; endsequence
  property p_take; s_take |-> address_latch_strobe && busy; endproperty
  a_take: assert property (p_take) else $error("ready without latch");
  property p_ale; $fell(address_latch_strobe) |-> t_q == ea; endproperty
  a_ale: assert property (p_ale) else $error("latch width");
  property p_cs; $fell(cs_low) |-> t_q == es && !address_latch_strobe; endproperty
  a_cs: assert property (p_cs) else $error("select start");
  property p_dsf; $fell(data_strobe_low) |-> t_q == es && !cs_low; endproperty
  a_dsf: assert property (p_dsf) else $error("setup length");
  property p_dsr; $rose(data_strobe_low) |-> t_q == ed; endproperty
  a_dsr: assert property (p_dsr) else $error("strobe width");
  property p_csr; $rose(cs_low) |-> t_q == eh; endproperty
  a_csr: assert property (p_csr) else $error("hold length");
  property p_wr; !cs_low && $past(!cs_low) && !rnw |-> ad_oe && $stable(ad_out); endproperty
  a_wr: assert property (p_wr) else $error("write data moved");
  property p_ord; address_latch_strobe |-> cs_low && data_strobe_low && ad_oe; endproperty
  a_ord: assert property (p_ord) else $error("phase overlap");
endmodule
bind mxb_seq mxb_seq_asserts chk_u (.sys_clk, .reset_n, .timing, .req_ready,
  .address_latch_strobe, .cs_low, .data_strobe_low, .rnw, .ad_out, .ad_oe, .busy);
`default_nettype wire

/* tb/mxb_periph.sv */
// external peripheral model on the shared lines
`timescale 1ns/1ps
`default_nettype none
module mxb_periph (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // reset
  input wire logic address_latch_strobe, // latch
  input wire logic cs_low, // select
  input wire logic data_strobe_low, // strobe
  input wire logic rnw, // read
  input wire logic [15:0] ad_out, // device drive
  output logic [15:0] ad_in, // pad value
  output logic [15:0] wr_word // last write
);
  logic [15:0] a_q;
  always_ff @(posedge sys_clk) begin
    if (address_latch_strobe) a_q <= ad_out;
    if (!reset_n) ad_in <= 16'h0;
    else if (!cs_low && rnw) ad_in <= ~a_q;
    else ad_in <= ~ad_in; // released lines toggle
    if (!rnw && $rose(data_strobe_low)) wr_word <= ad_out;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// random access bench for the expansion bus sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 0, reset_n = 0, req_valid = 0;
  mxb_pkg::mxb_timing_t timing = '0;
  mxb_pkg::mxb_req_t req = '0;
  logic req_ready, ale, cs_low, ds_low, rnw, ad_oe, rdata_valid, busy;
  logic [15:0] ad_in, ad_out, rdata, wr_word, got;
  logic [31:0] lf = 32'ha9afa879;
  int mismatches = 0, checked = 0, n;
  always #2 sys_clk = ~sys_clk;
  mxb_seq dut_u (.sys_clk, .reset_n, .clk_en(1'b1), .timing, .req, .req_valid, .ad_in,
    .req_ready, .address_latch_strobe(ale), .cs_low, .data_strobe_low(ds_low), .rnw,
    .ad_out, .ad_oe, .rdata, .rdata_valid, .busy);
  mxb_periph per_u (.sys_clk, .reset_n, .address_latch_strobe(ale), .cs_low,
    .data_strobe_low(ds_low), .rnw, .ad_out, .ad_in, .wr_word);
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] len_f(mxb_pkg::mxb_timing_t t);
    return 16'(t.address_phase_len) + 16'(t.setup_phase_len) + 16'(t.strobe_phase_len)
      + 16'(t.hold_phase_len) + 16'(t.recovery_phase_len) + 16'h5;
  endfunction
  task automatic cmp(logic [15:0] g, logic [15:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    reset_n = 1;
    for (int i = 0; i < 60; i++) begin
      lf = nx(lf);
      // shortest and longest phases first
      timing = i == 0 ? '0 : i == 1 ? '1 : lf[13:0];
      req = {i == 1 ? 1'b0 : lf[20], lf[15:0], lf[31:16]};
      req_valid = 1;
      for (n = 0; req_ready !== 1'b1; n++) begin
        if (n > 40) begin
          mismatches++;
          summarize();
        end
        @(negedge sys_clk);
      end
      req_valid = 0;
      got = 16'h0;
      for (n = 0; busy === 1'b1; n++) begin
        if (rdata_valid === 1'b1) got = rdata;
        if (n > 60) begin
          mismatches++;
          summarize();
        end
        @(negedge sys_clk);
      end
      cmp(16'(n), len_f(timing));
      if (req.write) cmp(wr_word, req.wdata);
      else if (timing.strobe_phase_len > 4'h2) cmp(got, ~req.addr);
    end
    summarize();
  end
endmodule
`default_nettype wire
